/* dtc_core.sv */
/*
  Four-channel single-transfer controller: APB register slave, trigger
  capture, fixed-priority arbitration and a read / idle / write sequencer
  with 8/16/32-bit width conversion on the internal system bus.
  Assumes one clock pclk, trigger pulses and bus_ready synchronous to it,
  and a bus that holds no request of ours except while bus_held is high.
*/
// Added by the designer: the register addresses and the APB slave port.
// What this block does
// (R1) six-bit trigger select per channel; zero means no request starts transfers
// (R2) codes 1 to 45 map to fixed on-chip requests; higher codes prohibited
// (R3) software must not use ROM targets or RAM to RAM copies
// (R4) single transfer mode only: one item, then bus given back
// (R5) each later request gives one more transfer until count reaches terminal
// (R6) after bus release a pending higher-priority channel is served first
// (R7) request for a channel during its own transfer cycle is discarded
// (R8) lower-priority request during a cycle waits until bus returned to CPU
// (R9) each transfer is a read of source then a write of destination
// (R10) exactly one idle clock between read cycle and write cycle
// (R11) 32-bit to 16-bit target: one read, upper half undriven, one 16-bit write
// (R12) 16/32-bit to 8-bit target: one 16-bit read then two 8-bit writes
// (R13) 8-bit to 16/32-bit target: two 8-bit reads then one 16-bit write
// (R14) between 16-bit and 32-bit targets: one 16-bit read, one 16-bit write
// (R15) peripherals are 16-bit, internal RAM 32-bit, external memory 8 or 16-bit
// (R16) software picks transfer size equal to a peripheral register's width
// (R17) fixed priority channel 0 highest, re-evaluated on every transfer cycle
// (R18) selected trigger sets pending even if disabled; enabling then starts at once
// (R19) triggers during standby neither start a transfer nor set pending
// (R20) at terminal count clear enable, set terminal flag, raise transfer-end irq
// (R21) prohibited trigger codes behave like the disabled code
`timescale 1ns/1ns
module dtc_core #(
  parameter int NUM_CH = dtc_pkg::NUM_CH,
  parameter int NUM_TRIG = dtc_pkg::NUM_TRIG
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dtc_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_TRIG-1:0] trig_lines,
  input wire logic standby,
  output dtc_pkg::dtc_bus_req_t bus_out,
  input wire logic bus_ready,
  input wire logic [15:0] bus_rdata,
  output logic bus_held,
  output logic [NUM_CH-1:0] transfer_end_irq
);
  localparam int IW = $clog2(NUM_CH);
  localparam int W = dtc_pkg::TRIG_W;
  localparam int AW = dtc_pkg::ADDR_W;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_GAP,
    ST_WRITE,
    ST_RELEASE
  } dtc_state_t;

  dtc_state_t state;
  logic [IW-1:0] cur;
  logic phase;
  logic [15:0] dbuf;
  logic [AW-1:0] src_addr [NUM_CH];
  logic [AW-1:0] dst_addr [NUM_CH];
  logic [dtc_pkg::CNT_W-1:0] count [NUM_CH];
  dtc_pkg::dtc_ctrl_t ctrl [NUM_CH];
  logic [NUM_CH-1:0] request_pending_flag;
  logic [NUM_CH-1:0] terminal_count_flag;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  logic setup_rd;
  logic acc_wr;
  logic acc_rd;
  logic [IW-1:0] reg_ch;
  logic [dtc_pkg::PADDR_W-1:0] reg_off;
  logic is_status;
  logic is_chan;

  assign setup_rd = psel && !penable && !pwrite;
  assign acc_wr = psel && penable && pready && pwrite && !pslverr;
  assign acc_rd = psel && penable && pready && !pwrite && !pslverr;
  assign reg_ch = paddr[dtc_pkg::CH_LSB +: IW];
  assign reg_off = {{(dtc_pkg::PADDR_W-dtc_pkg::REG_W){1'b0}}, paddr[dtc_pkg::REG_W-1:0]};
  assign is_status = (paddr == dtc_pkg::OFF_STATUS);
  assign is_chan = (paddr < dtc_pkg::OFF_STATUS) && (paddr[1:0] == 2'h0);

  ////////////////////////////////////////////////////////////////////////////
  // trigger decode and arbitration
  logic [NUM_CH-1:0] hit;
  logic [NUM_CH-1:0] enables;
  logic [NUM_CH*W-1:0] sel_flat;
  logic [IW-1:0] winner;
  logic win_valid;
  logic [NUM_CH-1:0] cur_onehot;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_flat
      assign sel_flat[g*W +: W] = ctrl[g].trig;
      assign enables[g] = ctrl[g].enable;
      assign cur_onehot[g] = (cur == IW'(g));
    end
  endgenerate

  dtc_trig #(.NUM_CH(NUM_CH), .NUM_TRIG(NUM_TRIG)) u_trig (
    .trig_lines(trig_lines),
    .sel(sel_flat),
    .candidates(request_pending_flag & enables), // see (R18)
    .hit(hit),
    .winner(winner),
    .win_valid(win_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // width plan of the active channel
  logic src8;
  logic dst8;
  logic two_reads;
  logic two_writes;
  logic rd_half;
  logic wr_half;
  logic in_cycle;
  logic grant;
  logic last_write;
  logic done;

  // peripheral 16-bit and RAM 32-bit read as 16; only ext8 is byte wide
  assign src8 = (ctrl[cur].src_kind == dtc_pkg::DTC_KIND_EXT8); // see (R15)
  assign dst8 = (ctrl[cur].dst_kind == dtc_pkg::DTC_KIND_EXT8); // see (R15)
  assign two_reads = ctrl[cur].half && src8; // see (R13)
  assign two_writes = ctrl[cur].half && dst8; // see (R12)
  assign rd_half = ctrl[cur].half && !src8; // see (R11) see (R14)
  assign wr_half = ctrl[cur].half && !dst8; // see (R14)
  assign in_cycle = (state == ST_READ) || (state == ST_GAP) || (state == ST_WRITE);
  assign grant = (state == ST_IDLE) && win_valid; // see (R6)
  assign last_write = !two_writes || phase;
  assign done = (state == ST_WRITE) && bus_ready && last_write;
  logic [NUM_CH-1:0] set_pend;
  logic [NUM_CH-1:0] clr_pend;
  logic [NUM_CH-1:0] set_tc;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_flags
      assign set_pend[g] = hit[g] && !standby && !(in_cycle && cur_onehot[g]); // see (R7) see (R18) see (R19)
      assign clr_pend[g] = (grant && winner == IW'(g))
        || (acc_wr && is_status && !pwdata[dtc_pkg::STAT_PEND_LSB + g]);
      assign set_tc[g] = done && cur_onehot[g] && count[g] <= dtc_pkg::CNT_W'(1);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: read, one idle clock, write, then bus back for at least two clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cur <= '0;
      phase <= 1'b0;
      dbuf <= 16'h0000;
      bus_out <= dtc_pkg::BUS_IDLE;
      bus_held <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (win_valid) begin
            cur <= winner; // see (R17)
            phase <= 1'b0;
            bus_held <= 1'b1;
            bus_out.req <= 1'b1;
            bus_out.write <= 1'b0;
            bus_out.half <= ctrl[winner].half && (ctrl[winner].src_kind != dtc_pkg::DTC_KIND_EXT8);
            bus_out.addr <= src_addr[winner]; // see (R9)
            bus_out.wdata <= 16'h0000;
            state <= ST_READ;
          end
        end
        ST_READ: begin
          if (bus_ready) begin
            if (two_reads) begin
              if (phase) begin
                dbuf[15:8] <= bus_rdata[7:0];
              end else begin
                dbuf[7:0] <= bus_rdata[7:0];
              end
            end else begin
              dbuf <= rd_half ? bus_rdata : {8'h00, bus_rdata[7:0]};
            end
            if (two_reads && !phase) begin
              phase <= 1'b1;
              bus_out.addr <= src_addr[cur] + dtc_pkg::STEP_BYTE; // see (R13)
            end else begin
              phase <= 1'b0;
              bus_out <= dtc_pkg::BUS_IDLE;
              state <= ST_GAP; // see (R10)
            end
          end
        end
        ST_GAP: begin
          bus_out.req <= 1'b1;
          bus_out.write <= 1'b1;
          bus_out.half <= wr_half;
          bus_out.addr <= dst_addr[cur]; // see (R9)
          bus_out.wdata <= two_writes ? {8'h00, dbuf[7:0]} : dbuf;
          state <= ST_WRITE;
        end
        ST_WRITE: begin
          if (bus_ready) begin
            if (!last_write) begin
              phase <= 1'b1;
              bus_out.addr <= dst_addr[cur] + dtc_pkg::STEP_BYTE; // see (R12)
              bus_out.wdata <= {8'h00, dbuf[15:8]};
            end else begin
              phase <= 1'b0;
              bus_out <= dtc_pkg::BUS_IDLE;
              bus_held <= 1'b0; // see (R4)
              state <= ST_RELEASE;
            end
          end
        end
        ST_RELEASE: begin
          state <= ST_IDLE; // see (R8)
        end
        default: begin
          state <= ST_IDLE;
          bus_out <= dtc_pkg::BUS_IDLE;
          bus_held <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel registers: software writes, then end-of-transfer updates on top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        src_addr[i] <= dtc_pkg::ADDR_RESET;
        dst_addr[i] <= dtc_pkg::ADDR_RESET;
        count[i] <= dtc_pkg::CNT_RESET;
        ctrl[i] <= dtc_pkg::CTRL_RESET;
      end
    end else begin
      if (acc_wr && is_chan) begin
        case (reg_off)
          dtc_pkg::OFF_SRC: src_addr[reg_ch] <= pwdata;
          dtc_pkg::OFF_DST: dst_addr[reg_ch] <= pwdata;
          dtc_pkg::OFF_CNT: count[reg_ch] <= pwdata[dtc_pkg::CNT_W-1:0];
          dtc_pkg::OFF_CTRL: begin
            ctrl[reg_ch].trig <= pwdata[dtc_pkg::CTRL_TRIG_LSB +: W];
            ctrl[reg_ch].enable <= pwdata[dtc_pkg::CTRL_EN_BIT];
            ctrl[reg_ch].half <= pwdata[dtc_pkg::CTRL_HALF_BIT];
            ctrl[reg_ch].src_kind <= dtc_pkg::dtc_kind_t'(pwdata[dtc_pkg::CTRL_SRC_LSB +: 2]);
            ctrl[reg_ch].dst_kind <= dtc_pkg::dtc_kind_t'(pwdata[dtc_pkg::CTRL_DST_LSB +: 2]);
          end
          default: begin
          end
        endcase
      end
      if (done) begin
        src_addr[cur] <= src_addr[cur] + (ctrl[cur].half ? dtc_pkg::STEP_HALF : dtc_pkg::STEP_BYTE);
        dst_addr[cur] <= dst_addr[cur] + (ctrl[cur].half ? dtc_pkg::STEP_HALF : dtc_pkg::STEP_BYTE);
        count[cur] <= count[cur] - 1'b1; // see (R5)
        if (count[cur] <= dtc_pkg::CNT_W'(1)) begin
          ctrl[cur].enable <= 1'b0; // see (R20)
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pending and terminal flags; a hardware set beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_pending_flag <= '0;
      terminal_count_flag <= '0;
      transfer_end_irq <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (set_pend[i]) begin
          request_pending_flag[i] <= 1'b1;
        end else if (clr_pend[i]) begin
          request_pending_flag[i] <= 1'b0;
        end
        if (set_tc[i]) begin
          terminal_count_flag[i] <= 1'b1; // see (R20)
        end else if (acc_rd && is_status) begin
          terminal_count_flag[i] <= 1'b0;
        end
        transfer_end_irq[i] <= set_tc[i]; // see (R20)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: data latched in setup, pready in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !is_status && !is_chan;
      if (setup_rd) begin
        prdata <= 32'h0000_0000;
        if (is_status) begin
          prdata[dtc_pkg::STAT_PEND_LSB +: NUM_CH] <= request_pending_flag;
          prdata[dtc_pkg::STAT_TC_LSB +: NUM_CH] <= terminal_count_flag;
          prdata[dtc_pkg::STAT_BUSY_BIT] <= bus_held;
        end else if (is_chan) begin
          case (reg_off)
            dtc_pkg::OFF_SRC: prdata <= src_addr[reg_ch];
            dtc_pkg::OFF_DST: prdata <= dst_addr[reg_ch];
            dtc_pkg::OFF_CNT: prdata[dtc_pkg::CNT_W-1:0] <= count[reg_ch];
            dtc_pkg::OFF_CTRL: begin
              prdata[dtc_pkg::CTRL_TRIG_LSB +: W] <= ctrl[reg_ch].trig;
              prdata[dtc_pkg::CTRL_EN_BIT] <= ctrl[reg_ch].enable;
              prdata[dtc_pkg::CTRL_HALF_BIT] <= ctrl[reg_ch].half;
              prdata[dtc_pkg::CTRL_SRC_LSB +: 2] <= ctrl[reg_ch].src_kind;
              prdata[dtc_pkg::CTRL_DST_LSB +: 2] <= ctrl[reg_ch].dst_kind;
            end
            default: begin
            end
          endcase
        end
      end
    end
  end

endmodule // dtc_core

/* dtc_pkg.sv */
/*
  Shared constants and types of the four-channel transfer controller:
  register offsets, field positions, reset values and bus carriers.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dtc_pkg;

  localparam int NUM_CH = 4;
  localparam int TRIG_W = 6;
  localparam int NUM_TRIG = 45;
  localparam int ADDR_W = 32;
  localparam int CNT_W = 16;
  localparam int PADDR_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register map: per channel block of four words, one status word
  localparam logic [PADDR_W-1:0] OFF_SRC = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_DST = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_CNT = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h0C;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h40;
  localparam int CH_LSB = 4;
  localparam int REG_W = 4;

  // control word fields
  localparam int CTRL_TRIG_LSB = 0;
  localparam int CTRL_EN_BIT = 8;
  localparam int CTRL_HALF_BIT = 9;
  localparam int CTRL_SRC_LSB = 10;
  localparam int CTRL_DST_LSB = 12;

  // status word fields
  localparam int STAT_PEND_LSB = 0;
  localparam int STAT_TC_LSB = 8;
  localparam int STAT_BUSY_BIT = 16;

  // reset values and address steps
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [ADDR_W-1:0] STEP_BYTE = 32'h0000_0001;
  localparam logic [ADDR_W-1:0] STEP_HALF = 32'h0000_0002;

  ////////////////////////////////////////////////////////////////////////////
  // target kind decides the bus width seen by the sequencer
  typedef enum logic [1:0] {
    DTC_KIND_PERIPH,
    DTC_KIND_RAM,
    DTC_KIND_EXT8,
    DTC_KIND_EXT16
  } dtc_kind_t;

  typedef struct packed {
    dtc_kind_t dst_kind;
    dtc_kind_t src_kind;
    logic half;
    logic enable;
    logic [TRIG_W-1:0] trig;
  } dtc_ctrl_t;

  localparam dtc_ctrl_t CTRL_RESET = '{DTC_KIND_PERIPH, DTC_KIND_PERIPH, 1'b0, 1'b0, 6'h00};

  // one request on the internal system bus, held until bus_ready
  typedef struct packed {
    logic req;
    logic write;
    logic half;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } dtc_bus_req_t;

  localparam dtc_bus_req_t BUS_IDLE = '{1'b0, 1'b0, 1'b0, 32'h0000_0000, 16'h0000};

endpackage

/* dtc_trig.sv */
/*
  Trigger decoder and fixed-priority picker of the transfer controller.
  Assumes trigger lines are single-clock pulses synchronous to pclk.
*/
`timescale 1ns/1ns
module dtc_trig #(
  parameter int NUM_CH = dtc_pkg::NUM_CH,
  parameter int NUM_TRIG = dtc_pkg::NUM_TRIG
) (
  input wire logic [NUM_TRIG-1:0] trig_lines,
  input wire logic [NUM_CH*dtc_pkg::TRIG_W-1:0] sel,
  input wire logic [NUM_CH-1:0] candidates,
  output logic [NUM_CH-1:0] hit,
  output logic [$clog2(NUM_CH)-1:0] winner,
  output logic win_valid
);
  localparam int W = dtc_pkg::TRIG_W;
  localparam int IW = $clog2(NUM_CH);

  // code k selects line k-1; code zero and codes above the table hit nothing
  logic [(1<<W)-1:0] lines_ext;
  assign lines_ext = {{((1<<W)-NUM_TRIG-1){1'b0}}, trig_lines, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_dec
      logic [W-1:0] code;
      assign code = sel[ch*W +: W];
      assign hit[ch] = (code != '0) && (code <= W'(NUM_TRIG)) && lines_ext[code]; // see (R1) see (R2) see (R21)
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // channel 0 highest, scanned from the lowest priority up
  always_comb begin
    winner = '0;
    win_valid = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (candidates[i]) begin
        winner = IW'(i); // see (R17)
        win_valid = 1'b1;
      end
    end
  end

endmodule // dtc_trig

/* dtc_core_properties.sv */
/*
  Port checker of the transfer controller: bus sequencing and APB answer.
  Assumes one pclk domain and a bind onto every dtc_core instance.
*/
`timescale 1ns/1ns
module dtc_core_chk #(
  parameter int NUM_CH = dtc_pkg::NUM_CH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire dtc_pkg::dtc_bus_req_t bus_out,
  input wire logic bus_ready,
  input wire logic bus_held,
  input wire logic [NUM_CH-1:0] transfer_end_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_rd_done;
    bus_out.req && !bus_out.write && bus_ready;
  endsequence
  sequence s_gap;
    !bus_out.req;
  endsequence
  property p_one_idle;
    s_rd_done ##1 s_gap |=> bus_out.req;
  endproperty
  a_one_idle: assert property (p_one_idle) else $error("idle after read longer than one clock");
  property p_no_direct;
    s_rd_done |=> !(bus_out.req && bus_out.write);
  endproperty
  a_no_direct: assert property (p_no_direct) else $error("write followed read with no idle clock");
  property p_read_first;
    $rose(bus_held) |-> bus_out.req && !bus_out.write;
  endproperty
  a_read_first: assert property (p_read_first) else $error("cycle did not open with a read");
  property p_release;
    $fell(bus_held) |-> $past(bus_ready && bus_out.write) ##0 s_gap [*2];
  endproperty
  a_release: assert property (p_release) else $error("bus not given back after the write");
  property p_req_hold;
    bus_out.req && !bus_ready |=> bus_out.req && $stable(bus_out.addr) && $stable(bus_out.write);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("bus request changed before ready");
  property p_req_in_hold;
    bus_out.req |-> bus_held;
  endproperty
  a_req_in_hold: assert property (p_req_in_hold) else $error("request outside bus ownership");
  property p_irq_end;
    |transfer_end_irq |-> !bus_held && $past(bus_ready && bus_out.write);
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("end pulse not right after last write");
  property p_apb_ready;
    psel && !penable |=> pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("no ready in access cycle");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule // dtc_core_chk

bind dtc_core dtc_core_chk #(.NUM_CH(NUM_CH)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .bus_out(bus_out), .bus_ready(bus_ready),
  .bus_held(bus_held), .transfer_end_irq(transfer_end_irq));

/* dtc_bus_model.sv */
/*
  Far side model: system bus whose targets answer after a set wait.
  Assumes requests held until bus_ready; logs every access in queues.
*/
`timescale 1ns/1ns
module dtc_bus_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire dtc_pkg::dtc_bus_req_t bus_out,
  input wire logic [3:0] wait_cycles,
  output logic bus_ready,
  output logic [15:0] bus_rdata
);
  logic [3:0] cnt;
  logic [31:0] ra[$];
  logic rh[$];
  logic [31:0] wa[$];
  logic [15:0] wd[$];
  logic wh[$];
  ////////////////////////////////////////////////////////////////////////////
  // read data only valid with ready, otherwise toggles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      bus_ready <= 1'b0;
      bus_rdata <= 16'hFFFF;
    end else begin
      bus_ready <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_out.req && !bus_ready) begin
        if (cnt == wait_cycles) begin
          cnt <= 4'h0;
          bus_ready <= 1'b1;
          if (bus_out.write) begin
            wa.push_back(bus_out.addr);
            wd.push_back(bus_out.wdata);
            wh.push_back(bus_out.half);
          end else begin
            bus_rdata <= bus_out.addr[15:0] ^ 16'hC35A;
            ra.push_back(bus_out.addr);
            rh.push_back(bus_out.half);
          end
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // dtc_bus_model

/* tb.sv */
/*
  Self-checking bench of dtc_core: APB master, trigger pulses, bus model.
  Assumes the checker is bound in and the bus model sits on bus_out.
*/
`timescale 1ns/1ns
module tb;
  typedef struct packed {
    logic [1:0] src;
    logic [1:0] dst;
    logic half;
    logic [3:0] wt;
    logic [1:0] nr;
    logic [1:0] nw;
  } dtc_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, standby, bus_ready, bus_held;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [44:0] trig_lines;
  logic [15:0] bus_rdata;
  logic [3:0] transfer_end_irq, wait_cycles, irq_seen;
  dtc_pkg::dtc_bus_req_t bus_out;
  int failures, checked;
  dtc_row_t rows [7];
  dtc_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_lines(trig_lines),
    .standby(standby), .bus_out(bus_out), .bus_ready(bus_ready), .bus_rdata(bus_rdata), .bus_held(bus_held),
    .transfer_end_irq(transfer_end_irq));
  dtc_bus_model bm (.pclk(pclk), .presetn(presetn), .bus_out(bus_out), .wait_cycles(wait_cycles),
    .bus_ready(bus_ready), .bus_rdata(bus_rdata));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) irq_seen <= presetn ? (irq_seen | transfer_end_irq) : 4'h0;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 10; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 10) failures++;
    if (i == 10) wrap_up();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input logic [5:0] t, input logic en, input logic h, input logic [1:0] s,
    input logic [1:0] d);
    return {18'h0, d, s, h, en, 2'h0, t};
  endfunction
  task automatic prog(input int ch, input logic [31:0] s, input logic [31:0] d, input logic [31:0] k);
    apb(1'b1, 8'(ch * 16) + dtc_pkg::OFF_SRC, s);
    apb(1'b1, 8'(ch * 16) + dtc_pkg::OFF_DST, d);
    apb(1'b1, 8'(ch * 16) + dtc_pkg::OFF_CNT, 32'h0000_0002);
    apb(1'b1, 8'(ch * 16) + dtc_pkg::OFF_CTRL, k);
  endtask
  task automatic fire(input logic [44:0] m);
    @(posedge pclk);
    trig_lines <= m;
    @(posedge pclk);
    trig_lines <= '0;
  endtask
  task automatic wait_wr(input int n);
    int i;
    for (i = 0; i < 3000 && bm.wa.size() < n; i++) @(posedge pclk);
    if (i == 3000) failures++;
    if (i == 3000) wrap_up();
    repeat (24) @(posedge pclk);
    check("write count", bm.wa.size(), n);
  endtask
  task automatic clear_log();
    bm.ra.delete();
    bm.rh.delete();
    bm.wa.delete();
    bm.wd.delete();
    bm.wh.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int nr, nw, i;
    logic [31:0] sa, da;
    logic [15:0] p0, p1, exp_w, mk;
    {presetn, psel, penable, pwrite, paddr, pwdata, trig_lines, standby, wait_cycles} = '0;
    failures = 0;
    checked = 0;
    // kinds: 0 peripheral, 1 internal RAM, 2 external 8-bit, 3 external 16-bit
    rows = '{'{2'h1, 2'h0, 1'b1, 4'h0, 2'h1, 2'h1}, '{2'h0, 2'h2, 1'b1, 4'h1, 2'h1, 2'h2},
      '{2'h1, 2'h2, 1'b1, 4'h0, 2'h1, 2'h2}, '{2'h2, 2'h0, 1'b1, 4'h2, 2'h2, 2'h1},
      '{2'h2, 2'h1, 1'b1, 4'h0, 2'h2, 2'h1}, '{2'h0, 2'h1, 1'b1, 4'h1, 2'h1, 2'h1},
      '{2'h3, 2'h0, 1'b0, 4'h0, 2'h1, 2'h1}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[r]) begin
      sa = 32'h0000_2000 + 32'(r * 16);
      da = 32'h0000_8000 + 32'(r * 16);
      nr = rows[r].nr;
      nw = rows[r].nw;
      p0 = sa[15:0] ^ 16'hC35A;
      p1 = (sa[15:0] + 16'h0001) ^ 16'hC35A;
      exp_w = (nr == 2) ? {p1[7:0], p0[7:0]} : p0;
      mk = (nw == 1 && rows[r].half) ? 16'hFFFF : 16'h00FF;
      wait_cycles <= rows[r].wt;
      clear_log();
      prog(0, sa, da, ctl(6'h01, 1'b1, rows[r].half, rows[r].src, rows[r].dst));
      fire(45'h1);
      wait_wr(nw);
      check("read count", bm.ra.size(), nr);
      for (int k = 0; k < nr; k++) begin
        check("read addr", bm.ra[k], sa + 32'(k));
        check("read size", bm.rh[k], nr == 1 && rows[r].half);
      end
      for (int k = 0; k < nw; k++) begin
        check("write addr", bm.wa[k], da + 32'(k));
        check("write data", bm.wd[k] & mk, (exp_w >> (8 * k)) & mk);
        check("write size", bm.wh[k], nw == 1 && rows[r].half);
      end
      fire(45'h1);
      wait_wr(2 * nw);
      check("next address", bm.wa[nw], da + 32'(rows[r].half ? 2 : 1));
      check("end flag", irq_seen, 4'h1);
    end
    apb(1'b0, dtc_pkg::OFF_STATUS, 32'h0);
    check("terminal flag", rd[11:8], 4'h1);
    apb(1'b0, dtc_pkg::OFF_STATUS, 32'h0);
    check("terminal cleared", rd[11:8], 4'h0);
    apb(1'b0, dtc_pkg::OFF_CTRL, 32'h0);
    check("enable cleared", rd[8], 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    check("held in reset", bus_held, 1'b0);
    presetn <= 1'b1;
    apb(1'b0, dtc_pkg::OFF_CTRL, 32'h0);
    check("ctrl reset", rd, 32'(dtc_pkg::CTRL_RESET));
    apb(1'b0, 8'h44, 32'h0);
    check("unmapped", err, 1'b1);
    apb(1'b0, dtc_pkg::OFF_STATUS, 32'h0);
    check("status reset", rd, 32'h0);
    prog(1, 32'h3000, 32'h9000, ctl(6'h2D, 1'b0, 1'b1, 2'h1, 2'h0));
    prog(2, 32'h3000, 32'h9000, ctl(6'h00, 1'b1, 1'b1, 2'h1, 2'h0));
    prog(3, 32'h3000, 32'h9000, ctl(6'h3F, 1'b1, 1'b1, 2'h1, 2'h0));
    clear_log();
    @(posedge pclk);
    standby <= 1'b1;
    fire('1);
    standby <= 1'b0;
    apb(1'b0, dtc_pkg::OFF_STATUS, 32'h0);
    check("standby pending", rd[3:0], 4'h0);
    fire('1);
    apb(1'b0, dtc_pkg::OFF_STATUS, 32'h0);
    check("pending while disabled", rd[3:0], 4'h2);
    apb(1'b1, dtc_pkg::OFF_STATUS, 32'h0);
    apb(1'b0, dtc_pkg::OFF_STATUS, 32'h0);
    check("pending cleared", rd[3:0], 4'h0);
    wait_wr(0);
    fire('1);
    apb(1'b1, 8'h1C, ctl(6'h2D, 1'b1, 1'b1, 2'h1, 2'h0));
    wait_wr(1);
    clear_log();
    wait_cycles <= 4'h3;
    for (int c = 0; c < 4; c++) prog(c, 32'h3000, 32'h0000_A000 + 32'(c * 256), ctl(6'(c + 2), 1'b1, 1'b1, 2'h0, 2'h1));
    fire(45'h1E);
    for (i = 0; i < 100 && bus_held !== 1'b1; i++) @(posedge pclk);
    if (i == 100) failures++;
    if (i == 100) wrap_up();
    fire(45'h2);
    wait_wr(4);
    for (int c = 0; c < 4; c++) check("priority order", bm.wa[c], 32'h0000_A000 + 32'(c * 256));
    fire(45'h1E);
    wait_wr(8);
    check("all ended", irq_seen, 4'hF);
    fire(45'h1E);
    wait_wr(8);
    wrap_up();
  end
endmodule // tb
